// *** inc/ccr_pkg.sv ***
// shared constants and types for the comparator control register bank
package ccr_pkg;

    // special-function-register addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h9B;
    localparam logic [7:0] ADDR_MODE0 = 8'h9D;
    localparam logic [7:0] ADDR_MUX0 = 8'h9F;
    localparam logic [7:0] ADDR_MUX1 = 8'h9F;

    // control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_RESULT_BIT = 6;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;

    // mode register fields
    localparam int MODE_RESV_BIT = 7;
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_SPD_LSB = 0;
    localparam logic [7:0] MODE_WMASK = 8'h33;

    // input select register fields
    localparam int MUX_NEG_LSB = 4;
    localparam int MUX_POS_LSB = 0;
    localparam logic [1:0] MUX_RESV_TOP = 2'h3;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h02;
    localparam logic [7:0] MUX_RST = 8'hFF;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int POWER_UP_NS = 2300;
    localparam int POWER_UP_CYC = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 5;

    typedef enum logic [1:0] {
        HYST_OFF = 2'h0,
        HYST_5MV = 2'h1,
        HYST_10MV = 2'h2,
        HYST_20MV = 2'h3
    } ccr_hyst_t;

    typedef enum logic [1:0] {
        SPD_FASTEST = 2'h0,
        SPD_MID_FAST = 2'h1,
        SPD_MID_LOW = 2'h2,
        SPD_LOWEST_POWER = 2'h3
    } ccr_speed_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ccr_sfr_req_t;

    typedef struct packed {
        logic cmp_enable;
        ccr_hyst_t pos_hyst_sel;
        ccr_hyst_t neg_hyst_sel;
        ccr_speed_t speed_power_sel;
        logic [3:0] cmp_a_neg_sel;
        logic [3:0] cmp_a_pos_sel;
        logic [3:0] cmp_b_neg_sel;
        logic [3:0] cmp_b_pos_sel;
    } ccr_analog_cfg_t;

endpackage : ccr_pkg

// *** design/ccr_sync.sv ***
// multi-stage level synchroniser for the raw comparator output
`timescale 1ns/1ps
`default_nettype none

module ccr_sync #(
    parameter int STAGES = 2
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic async_in,
    output logic sync_out
);

    typedef struct packed {
        logic [STAGES-1:0] chain;
    } ccr_sync_state_t;

    ccr_sync_state_t s_q;
    ccr_sync_state_t s_d;

    initial begin
        if (STAGES < 2) begin
            $error("ccr_sync needs at least two stages");
        end
    end

    // first stage feeds only the second; nothing else taps it
    always_comb begin
        s_d = s_q;
        s_d.chain = {s_q.chain[STAGES-2:0], async_in};
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.chain[STAGES-1];

endmodule : ccr_sync

`default_nettype wire

// *** design/ccr_top.sv ***
// comparator control, mode and input select registers with edge flags
`timescale 1ns/1ps
`default_nettype none

module ccr_top #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clock,
    input wire logic srst,
    input wire ccr_pkg::ccr_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    input wire logic cmp_raw,
    output ccr_pkg::ccr_analog_cfg_t analog_cfg,
    output logic cmp_pin_out,
    output logic osc_wake,
    output logic irq,
    output logic cmp_settling,
    output logic mux_a_reserved,
    output logic mux_b_reserved
);

    typedef enum logic [1:0] {
        ST_OFF,
        ST_SETTLE,
        ST_READY
    } ccr_pwr_state_t;

    typedef struct packed {
        logic en;
        logic rise;
        logic fall;
        ccr_pkg::ccr_hyst_t hyp;
        ccr_pkg::ccr_hyst_t hyn;
        logic rie;
        logic fie;
        ccr_pkg::ccr_speed_t spd;
        logic [3:0] a_neg;
        logic [3:0] a_pos;
        logic [3:0] b_neg;
        logic [3:0] b_pos;
        logic prev;
        logic [7:0] rdata;
        logic rvalid;
        logic pin_out;
        logic wake;
        logic irq;
        ccr_pwr_state_t pwr;
        logic [ccr_pkg::SETTLE_W-1:0] settle_cnt;
        logic settling;
        logic a_resv;
        logic b_resv;
    } ccr_top_state_t;

    localparam logic [ccr_pkg::SETTLE_W-1:0] SETTLE_LOAD =
        ccr_pkg::SETTLE_W'(ccr_pkg::POWER_UP_CYC - 1);

    initial begin
        if (SYNC_STAGES < 2) begin
            $error("ccr_top needs at least two synchroniser stages");
        end
        if (ccr_pkg::POWER_UP_CYC > (1 << ccr_pkg::SETTLE_W)) begin
            $error("settle counter too narrow for the power-up time");
        end
    end

    ccr_top_state_t s_q;
    ccr_top_state_t s_d;

    logic result_sync;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_mux0;
    logic wr_mux1;
    logic rise_evt;
    logic fall_evt;
    logic cfg_change;
    logic [7:0] ctrl_view;
    logic [7:0] mode_view;
    logic [7:0] mux0_view;

    // raw result is asynchronous to the bus clock
    ccr_sync #(
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .async_in(cmp_raw),
        .sync_out(result_sync)
    );

    always_comb begin
        wr_ctrl = sfr_req.wr && (sfr_req.addr == ccr_pkg::ADDR_CTRL0);
        wr_mode = sfr_req.wr && (sfr_req.addr == ccr_pkg::ADDR_MODE0);
        wr_mux0 = sfr_req.wr && (sfr_req.addr == ccr_pkg::ADDR_MUX0);
        wr_mux1 = sfr_req.wr && (sfr_req.addr == ccr_pkg::ADDR_MUX1);
    end

    // edges count only while powered; a dead comparator makes no events
    always_comb begin
        rise_evt = s_q.en && result_sync && !s_q.prev;
        fall_evt = s_q.en && !result_sync && s_q.prev;
    end

    always_comb begin
        ctrl_view = '0;
        ctrl_view[ccr_pkg::CTRL_EN_BIT] = s_q.en;
        ctrl_view[ccr_pkg::CTRL_RESULT_BIT] = result_sync;
        ctrl_view[ccr_pkg::CTRL_RISE_BIT] = s_q.rise;
        ctrl_view[ccr_pkg::CTRL_FALL_BIT] = s_q.fall;
        ctrl_view[ccr_pkg::CTRL_HYP_LSB +: 2] = s_q.hyp;
        ctrl_view[ccr_pkg::CTRL_HYN_LSB +: 2] = s_q.hyn;
    end

    // unused and reserved mode bits are never stored, so they read zero
    always_comb begin
        mode_view = '0;
        mode_view[ccr_pkg::MODE_RIE_BIT] = s_q.rie;
        mode_view[ccr_pkg::MODE_FIE_BIT] = s_q.fie;
        mode_view[ccr_pkg::MODE_SPD_LSB +: 2] = s_q.spd;
    end

    always_comb begin
        mux0_view = '0;
        mux0_view[ccr_pkg::MUX_NEG_LSB +: 4] = s_q.a_neg;
        mux0_view[ccr_pkg::MUX_POS_LSB +: 4] = s_q.a_pos;
    end

    // a retune upsets the analog core just as a power-up does
    always_comb begin
        cfg_change = 1'b0;
        if (wr_ctrl) begin
            if (sfr_req.wdata[ccr_pkg::CTRL_HYP_LSB +: 2] != s_q.hyp) begin
                cfg_change = 1'b1;
            end
            if (sfr_req.wdata[ccr_pkg::CTRL_HYN_LSB +: 2] != s_q.hyn) begin
                cfg_change = 1'b1;
            end
        end
        if (wr_mode) begin
            if (sfr_req.wdata[ccr_pkg::MODE_SPD_LSB +: 2] != s_q.spd) begin
                cfg_change = 1'b1;
            end
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.prev = result_sync;
        s_d.rvalid = sfr_req.rd;

        // control register
        if (wr_ctrl) begin
            s_d.en = sfr_req.wdata[ccr_pkg::CTRL_EN_BIT];
            s_d.hyp = ccr_pkg::ccr_hyst_t'(sfr_req.wdata[ccr_pkg::CTRL_HYP_LSB +: 2]);
            s_d.hyn = ccr_pkg::ccr_hyst_t'(sfr_req.wdata[ccr_pkg::CTRL_HYN_LSB +: 2]);
            s_d.rise = sfr_req.wdata[ccr_pkg::CTRL_RISE_BIT];
            s_d.fall = sfr_req.wdata[ccr_pkg::CTRL_FALL_BIT];
        end

        // an edge in the clearing cycle still lands
        if (rise_evt) begin
            s_d.rise = 1'b1;
        end
        if (fall_evt) begin
            s_d.fall = 1'b1;
        end

        // mode register
        if (wr_mode) begin
            s_d.rie = sfr_req.wdata[ccr_pkg::MODE_RIE_BIT];
            s_d.fie = sfr_req.wdata[ccr_pkg::MODE_FIE_BIT];
            s_d.spd = ccr_pkg::ccr_speed_t'(sfr_req.wdata[ccr_pkg::MODE_SPD_LSB +: 2]);
        end

        // input select registers share one address, so one write sets both
        if (wr_mux0) begin
            s_d.a_neg = sfr_req.wdata[ccr_pkg::MUX_NEG_LSB +: 4];
            s_d.a_pos = sfr_req.wdata[ccr_pkg::MUX_POS_LSB +: 4];
        end
        if (wr_mux1) begin
            s_d.b_neg = sfr_req.wdata[ccr_pkg::MUX_NEG_LSB +: 4];
            s_d.b_pos = sfr_req.wdata[ccr_pkg::MUX_POS_LSB +: 4];
        end

        // reserved codes are stored as written; flagged for the analog mux
        s_d.a_resv = (s_d.a_neg[3:2] == ccr_pkg::MUX_RESV_TOP)
            || (s_d.a_pos[3:2] == ccr_pkg::MUX_RESV_TOP);
        s_d.b_resv = (s_d.b_neg[3:2] == ccr_pkg::MUX_RESV_TOP)
            || (s_d.b_pos[3:2] == ccr_pkg::MUX_RESV_TOP);

        // read data, registered one cycle after the strobe
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                ccr_pkg::ADDR_CTRL0: s_d.rdata = ctrl_view;
                ccr_pkg::ADDR_MODE0: s_d.rdata = mode_view;
                ccr_pkg::ADDR_MUX0: s_d.rdata = mux0_view;
                default: s_d.rdata = '0;
            endcase
        end

        // outputs follow the next state so they need no extra cycle
        s_d.pin_out = s_d.en && result_sync;
        s_d.wake = s_d.en && !result_sync;
        s_d.irq = (s_d.rise && s_d.rie) || (s_d.fall && s_d.fie);

        // settling window marks when flags may be spurious
        case (s_q.pwr)
            ST_OFF: begin
                if (s_d.en) begin
                    s_d.pwr = ST_SETTLE;
                    s_d.settle_cnt = SETTLE_LOAD;
                end
            end
            ST_SETTLE: begin
                if (!s_d.en) begin
                    s_d.pwr = ST_OFF;
                    s_d.settle_cnt = '0;
                end else if (cfg_change) begin
                    s_d.settle_cnt = SETTLE_LOAD;
                end else if (s_q.settle_cnt == '0) begin
                    s_d.pwr = ST_READY;
                end else begin
                    s_d.settle_cnt = s_q.settle_cnt - 1'b1;
                end
            end
            ST_READY: begin
                if (!s_d.en) begin
                    s_d.pwr = ST_OFF;
                end else if (cfg_change) begin
                    s_d.pwr = ST_SETTLE;
                    s_d.settle_cnt = SETTLE_LOAD;
                end
            end
            default: begin
                s_d.pwr = ST_OFF;
                s_d.settle_cnt = '0;
            end
        endcase

        // kept in its own flop so the output carries no decode logic
        s_d.settling = (s_d.pwr == ST_SETTLE);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q.en <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_EN_BIT];
            s_q.rise <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_RISE_BIT];
            s_q.fall <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_FALL_BIT];
            s_q.hyp <= ccr_pkg::ccr_hyst_t'(ccr_pkg::CTRL_RST[ccr_pkg::CTRL_HYP_LSB +: 2]);
            s_q.hyn <= ccr_pkg::ccr_hyst_t'(ccr_pkg::CTRL_RST[ccr_pkg::CTRL_HYN_LSB +: 2]);
            s_q.rie <= ccr_pkg::MODE_RST[ccr_pkg::MODE_RIE_BIT];
            s_q.fie <= ccr_pkg::MODE_RST[ccr_pkg::MODE_FIE_BIT];
            s_q.spd <= ccr_pkg::ccr_speed_t'(ccr_pkg::MODE_RST[ccr_pkg::MODE_SPD_LSB +: 2]);
            s_q.a_neg <= ccr_pkg::MUX_RST[ccr_pkg::MUX_NEG_LSB +: 4];
            s_q.a_pos <= ccr_pkg::MUX_RST[ccr_pkg::MUX_POS_LSB +: 4];
            s_q.b_neg <= ccr_pkg::MUX_RST[ccr_pkg::MUX_NEG_LSB +: 4];
            s_q.b_pos <= ccr_pkg::MUX_RST[ccr_pkg::MUX_POS_LSB +: 4];
            s_q.prev <= 1'b0;
            s_q.rdata <= '0;
            s_q.rvalid <= 1'b0;
            s_q.pin_out <= 1'b0;
            s_q.wake <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.pwr <= ST_OFF;
            s_q.settle_cnt <= '0;
            s_q.settling <= 1'b0;
            s_q.a_resv <= 1'b1;
            s_q.b_resv <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        analog_cfg.cmp_enable = s_q.en;
        analog_cfg.pos_hyst_sel = s_q.hyp;
        analog_cfg.neg_hyst_sel = s_q.hyn;
        analog_cfg.speed_power_sel = s_q.spd;
        analog_cfg.cmp_a_neg_sel = s_q.a_neg;
        analog_cfg.cmp_a_pos_sel = s_q.a_pos;
        analog_cfg.cmp_b_neg_sel = s_q.b_neg;
        analog_cfg.cmp_b_pos_sel = s_q.b_pos;
    end

    assign sfr_rdata = s_q.rdata;
    assign sfr_rvalid = s_q.rvalid;
    assign cmp_pin_out = s_q.pin_out;
    assign osc_wake = s_q.wake;
    assign irq = s_q.irq;
    assign cmp_settling = s_q.settling;
    assign mux_a_reserved = s_q.a_resv;
    assign mux_b_reserved = s_q.b_resv;

endmodule : ccr_top

`default_nettype wire

// *** tb/ccr_chk.sv ***
// assertion checker for the comparator register bank ports
`timescale 1ns/1ps
`default_nettype none
module ccr_chk #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clock,
    input wire logic srst,
    input wire ccr_pkg::ccr_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic cmp_raw,
    input wire ccr_pkg::ccr_analog_cfg_t analog_cfg,
    input wire logic cmp_pin_out,
    input wire logic osc_wake,
    input wire logic irq,
    input wire logic cmp_settling,
    input wire logic mux_a_reserved,
    input wire logic mux_b_reserved
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire logic w_ctl = sfr_req.wr && (sfr_req.addr == ccr_pkg::ADDR_CTRL0);
    wire logic w_mod = sfr_req.wr && (sfr_req.addr == ccr_pkg::ADDR_MODE0);
    wire logic w_mux = sfr_req.wr && (sfr_req.addr == ccr_pkg::ADDR_MUX0);
    wire logic en = analog_cfg.cmp_enable;

    a_ctrl_write_cfg: assert property (w_ctl |=>
        en == $past(sfr_req.wdata[7])
        && analog_cfg.pos_hyst_sel == $past(sfr_req.wdata[3:2])
        && analog_cfg.neg_hyst_sel == $past(sfr_req.wdata[1:0])) else $error("ctrl fields");
    a_mux_write: assert property (w_mux |=>
        {analog_cfg.cmp_a_neg_sel, analog_cfg.cmp_a_pos_sel} == $past(sfr_req.wdata)
        && {analog_cfg.cmp_b_neg_sel, analog_cfg.cmp_b_pos_sel} == $past(sfr_req.wdata))
        else $error("select fields");
    a_mode_speed: assert property (w_mod |=>
        analog_cfg.speed_power_sel == $past(sfr_req.wdata[1:0])) else $error("mode field");
    a_mode_zero_bits: assert property (
        sfr_req.rd && sfr_req.addr == ccr_pkg::ADDR_MODE0
        |=> (sfr_rdata & 8'hCC) == 8'h00) else $error("mode spare bits");
    a_result_read: assert property ($stable(cmp_raw)[*4] ##0
        (sfr_req.rd && sfr_req.addr == ccr_pkg::ADDR_CTRL0) |=> sfr_rdata[6] == $past(cmp_raw))
        else $error("result bit");
    a_pin_low_off: assert property (!en && !$past(en) |-> !cmp_pin_out)
        else $error("pin while off");
    a_wake_request: assert property (
        (en && !cmp_raw)[*5] |-> osc_wake && !cmp_pin_out) else $error("wake request");
    a_pin_follows: assert property (
        (en && cmp_raw)[*5] |-> cmp_pin_out && !osc_wake) else $error("pin level");
    a_irq_gated: assert property (
        w_mod && sfr_req.wdata[5:4] == 2'h0 ##1 !w_mod |=> !irq) else $error("irq while masked");
    a_reserved_flag: assert property ($stable(analog_cfg) |->
        mux_a_reserved == (analog_cfg.cmp_a_neg_sel[3:2] == 2'h3
        || analog_cfg.cmp_a_pos_sel[3:2] == 2'h3)
        && mux_b_reserved == (analog_cfg.cmp_b_neg_sel[3:2] == 2'h3
        || analog_cfg.cmp_b_pos_sel[3:2] == 2'h3)) else $error("reserved flag");
    a_settle_start: assert property (
        w_ctl && sfr_req.wdata[7] && !en |=> cmp_settling) else $error("no settle window");
endmodule : ccr_chk
`default_nettype wire

// *** tb/ccr_core_model.sv ***
// behavioural analog comparator core driving the raw result
`timescale 1ns/1ps
`default_nettype none
module ccr_core_model #(
    parameter int RESP_NS [4] = '{120, 200, 360, 2200}
) (
    input wire ccr_pkg::ccr_analog_cfg_t analog_cfg,
    input wire logic pos_above,
    output logic cmp_raw
);
    initial cmp_raw = 1'b0;
    // slower modes answer later, so the bench cannot lean on a fast core
    always @(pos_above) cmp_raw <= #(RESP_NS[analog_cfg.speed_power_sel]) pos_above;
endmodule : ccr_core_model
`default_nettype wire

// *** tb/ccr_top_tb.sv ***
// self-checking bench for the comparator register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_top_tb;
    logic clock = 1'b0;
    logic srst = 1'b1;
    ccr_pkg::ccr_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic sfr_rvalid, cmp_raw, cmp_pin_out, osc_wake, irq, mux_a_reserved, mux_b_reserved;
    logic cmp_settling;
    logic pos_above = 1'b0;
    ccr_pkg::ccr_analog_cfg_t analog_cfg;
    logic [7:0] expq[$];
    logic [7:0] d;
    int n_fail = 0;
    int comparisons = 0;
    localparam logic [7:0] CTL = ccr_pkg::ADDR_CTRL0;
    localparam logic [7:0] MOD = ccr_pkg::ADDR_MODE0;
    localparam logic [7:0] MUX = ccr_pkg::ADDR_MUX0;

    always #50 clock = ~clock;

    ccr_top dut (.clock, .srst, .sfr_req, .sfr_rdata, .sfr_rvalid, .cmp_raw, .analog_cfg,
        .cmp_pin_out, .osc_wake, .irq, .cmp_settling, .mux_a_reserved, .mux_b_reserved);
    ccr_core_model core (.analog_cfg, .pos_above, .cmp_raw);

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_out

    task automatic tally_and_finish();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // one strobe cycle then one idle cycle, so a strobe is never set twice at one time
    task automatic bus(input logic [7:0] a, input logic w, input logic r, input logic [7:0] wd,
        input logic [7:0] e);
        if (r) expq.push_back(e);
        sfr_req = '{a, w, r, wd};
        @(posedge clock);
        #10;
        sfr_req.wr = 1'b0;
        sfr_req.rd = 1'b0;
        @(posedge clock);
        #10;
    endtask : bus

    // {irq, pin, wake}; bounded so a dead output cannot hang the run
    task automatic wait_out(input logic [2:0] e);
        int i;
        for (i = 0; i < 100 && {irq, cmp_pin_out, osc_wake} !== e; i++) begin
            @(posedge clock);
            #10;
        end
        cmp_out({5'h0, irq, cmp_pin_out, osc_wake}, {5'h0, e});
        if (i == 100) tally_and_finish();
    endtask : wait_out

    always @(posedge clock) begin
        #1;
        if (sfr_rvalid === 1'b1) cmp_rd(sfr_rdata, expq.size() ? expq.pop_front() : 8'hXX);
    end

    initial begin
        void'($urandom(31));
        repeat (20) @(posedge clock);
        #10;
        srst = 1'b0;
        @(posedge clock);
        #10;
        bus(CTL, 0, 1, 0, ccr_pkg::CTRL_RST);
        bus(MOD, 0, 1, 0, ccr_pkg::MODE_RST);
        bus(MUX, 0, 1, 0, ccr_pkg::MUX_RST);
        bus(8'h9C, 0, 1, 0, 8'h00);
        cmp_out({6'h0, mux_a_reserved, mux_b_reserved}, 8'h03);
        for (int m = 0; m < 4; m++) begin
            bus(MOD, 1, 0, 8'(m) | (8'($urandom) & 8'h4C), 0);
            bus(MOD, 0, 1, 0, 8'(m));
        end
        for (int h = 0; h < 16; h++) begin
            d = {4'(h), 4'(~h)};
            bus(CTL, 1, 0, 8'(h) | 8'h40, 0);
            bus(CTL, 0, 1, 0, 8'(h));
            bus(MUX, 1, 0, d, 0);
            bus(MUX, 0, 1, 0, d);
            cmp_out({analog_cfg.cmp_b_neg_sel, analog_cfg.cmp_b_pos_sel}, d);
            cmp_out(8'(mux_a_reserved), {7'h0, d[7:6] == 2'h3 || d[3:2] == 2'h3});
        end
        bus(CTL, 1, 1, 8'h05, 8'h0F);
        bus(CTL, 0, 1, 0, 8'h05);
        bus(MOD, 1, 0, 8'h30, 0);
        bus(CTL, 1, 0, 8'h80, 0);
        cmp_out({7'h0, cmp_settling}, 8'h01);
        repeat (ccr_pkg::POWER_UP_CYC - 2) @(posedge clock);
        #10;
        cmp_out({7'h0, cmp_settling}, 8'h01);
        repeat (2) @(posedge clock);
        #10;
        cmp_out({7'h0, cmp_settling}, 8'h00);
        bus(CTL, 1, 0, 8'h80, 0);
        pos_above = 1'b1;
        wait_out(3'b110);
        bus(CTL, 0, 1, 0, 8'hE0);
        pos_above = 1'b0;
        wait_out(3'b101);
        bus(CTL, 0, 1, 0, 8'hB0);
        bus(CTL, 1, 0, 8'h80, 0);
        wait_out(3'b001);
        bus(MOD, 1, 0, 8'h10, 0);
        pos_above = 1'b1;
        wait_out(3'b010);
        bus(CTL, 0, 1, 0, 8'hE0);
        bus(MOD, 1, 0, 8'h20, 0);
        wait_out(3'b110);
        bus(MOD, 1, 0, 8'h10, 0);
        wait_out(3'b010);
        pos_above = 1'b0;
        wait_out(3'b101);
        bus(CTL, 1, 0, 8'h00, 0);
        pos_above = 1'b1;
        repeat (40) @(posedge clock);
        #10;
        cmp_out({5'h0, irq, cmp_pin_out, osc_wake}, 8'h00);
        bus(CTL, 0, 1, 0, 8'h40);
        cmp_rd(8'(expq.size()), 8'h00);
        tally_and_finish();
    end
endmodule : ccr_top_tb

bind ccr_top ccr_chk #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.clock, .srst, .sfr_req, .sfr_rdata,
    .sfr_rvalid, .cmp_raw, .analog_cfg, .cmp_pin_out, .osc_wake, .irq, .cmp_settling,
    .mux_a_reserved, .mux_b_reserved);
`default_nettype wire
